// ==== verilog/serial_gain_word_loader.sv ====
// serial gain word loader: three-wire gain port and power-down control
// assumes serial_clk comes from the host and may stop between frames;
// clk is the free-running system clock, arst_n resets both domains
`timescale 1ns/1ps
`include "gain_loader_defs.svh"
module serial_gain_word_loader (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_clk,
  input wire logic serial_load_enable_n,
  input wire logic serial_gain_data,
  input wire logic power_down_n,
  output logic [6:0] gain_code,
  output logic [6:0] applied_gain_step,
  output logic forward_enable,
  output logic reverse_enable,
  output logic gain_update
);
  // link domain: shift register clocked by serial_clk
  logic [`GAIN_BITS-1:0] shift_reg;
  logic [`GAIN_BITS-1:0] next_shift_reg;

  always_comb begin
    next_shift_reg = shift_reg;
    if (!serial_load_enable_n)
      next_shift_reg = {shift_reg[`GAIN_BITS-2:0], serial_gain_data};
  end

  // the eighth edge pushes the first bit out of the seven-bit register
  always_ff @(posedge serial_clk or negedge arst_n) begin
    if (!arst_n)
      shift_reg <= '0;
    else
      shift_reg <= next_shift_reg;
  end

  // shift_reg is stable once load enable is high, so the bus may be
  // synchronised as a group after the enable itself has crossed;
  // the enable crosses inverted so the synchroniser's reset value matches
  // the idle pin and no false load edge follows reset
  logic [2:0] ctl_sync;
  logic [`GAIN_BITS-1:0] word_sync;
  level_sync #(.WIDTH(3)) u_ctl_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({~serial_load_enable_n, power_down_n, 1'b0}),
    .sync_out(ctl_sync)
  );
  level_sync #(.WIDTH(`GAIN_BITS)) u_word_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(shift_reg),
    .sync_out(word_sync)
  );

  logic load_en_s;
  logic pd_n_s;
  assign load_en_s = ~ctl_sync[2];
  assign pd_n_s = ctl_sync[1];

  function automatic gain_loader_pkg::gain_code_t clamp_code(
    input gain_loader_pkg::gain_code_t code
  );
    if (code > `GAIN_MAX_CODE)
      clamp_code = `GAIN_MAX_CODE;
    else
      clamp_code = code;
  endfunction

  // one extra stage lets the word settle two cycles behind the enable edge
  logic load_en_d;
  logic load_en_d2;
  logic [`GAIN_BITS-1:0] gain_latch;
  logic [`GAIN_BITS-1:0] next_gain_latch;
  logic next_gain_update;

  always_comb begin
    next_gain_latch = gain_latch;
    next_gain_update = 1'b0;
    if (load_en_d && !load_en_d2) begin
      next_gain_latch = word_sync;
      next_gain_update = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      load_en_d <= 1'b1;
      load_en_d2 <= 1'b1;
      gain_latch <= `GAIN_RESET_CODE;
      gain_update <= 1'b0;
    end else begin
      load_en_d <= load_en_s;
      load_en_d2 <= load_en_d;
      gain_latch <= next_gain_latch;
      gain_update <= next_gain_update;
    end
  end

  assign gain_code = gain_latch;
  assign applied_gain_step = clamp_code(gain_latch);

  // power-down acts on the amplifier directly, not through the clock domain
  gain_loader_pkg::amp_mode_t mode;
  always_comb begin
    mode = power_down_n ? gain_loader_pkg::MODE_FORWARD
                        : gain_loader_pkg::MODE_REVERSE;
  end
  assign forward_enable = mode[0];
  assign reverse_enable = mode[1];
endmodule

// ==== verilog/gain_loader_defs.svh ====
// constants for the serial gain word loader
// assumes nothing; included by bare name
`ifndef GAIN_LOADER_DEFS_SVH
`define GAIN_LOADER_DEFS_SVH
`define FRAME_BITS 8
`define GAIN_BITS 7
`define GAIN_MAX_CODE 7'h47
`define GAIN_RESET_CODE 7'h00
`define GAIN_STEP_UDB 16'h1D66
`endif

// ==== verilog/gain_loader_pkg.sv ====
// types for the serial gain word loader
// assumes gain_loader_defs.svh is on the include path
`include "gain_loader_defs.svh"
package gain_loader_pkg;
  typedef logic [`GAIN_BITS-1:0] gain_code_t;
  typedef enum logic [1:0] {
    MODE_FORWARD = 2'h1,
    MODE_REVERSE = 2'h2
  } amp_mode_t;
endpackage

// ==== verilog/level_sync.sv ====
// two flip-flop synchroniser for a level crossing into clk
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule

// ==== verification/gain_host_model.sv ====
// host side of the three-wire gain port
// assumes the bench calls send between checks
`timescale 1ns/1ps
module gain_host_model (
  output logic serial_clk,
  output logic serial_load_enable_n,
  output logic serial_gain_data
);
  initial begin
    serial_clk = 0;
    serial_load_enable_n = 1;
    serial_gain_data = 0;
  end
  // clock runs only inside a frame, 125 ns period
  task automatic send(input logic [7:0] w);
    serial_load_enable_n = 0;
    for (int i = 7; i >= 0; i--) begin
      serial_gain_data = w[i];
      #62.5 serial_clk = 1;
      #62.5 serial_clk = 0;
    end
    serial_gain_data = ~w[0];
    serial_load_enable_n = 1;
    #200;
  endtask
endmodule

// ==== verification/gain_loader_monitor.sv ====
// checker on the loader ports
// assumes bind into serial_gain_word_loader
`timescale 1ns/1ps
module gain_loader_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_load_enable_n,
  input wire logic power_down_n,
  input wire logic [6:0] gain_code,
  input wire logic [6:0] applied_gain_step,
  input wire logic forward_enable,
  input wire logic reverse_enable,
  input wire logic gain_update
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_f; forward_enable == power_down_n; endproperty
  a_f: assert property (p_f) else $error("fwd");
  property p_r; reverse_enable != power_down_n; endproperty
  a_r: assert property (p_r) else $error("rev");
  property p_cl; applied_gain_step == (gain_code > 7'h47 ? 7'h47 : gain_code); endproperty
  a_cl: assert property (p_cl) else $error("clamp");
  property p_ch; $changed(gain_code) |-> gain_update; endproperty
  a_ch: assert property (p_ch) else $error("change");
  property p_lo; !serial_load_enable_n |-> !gain_update; endproperty
  a_lo: assert property (p_lo) else $error("early");
  property p_ld; $rose(serial_load_enable_n) |-> ##[3:6] gain_update; endproperty
  a_ld: assert property (p_ld) else $error("late");
  property p_pu; gain_update |=> !gain_update [*3]; endproperty
  a_pu: assert property (p_pu) else $error("pulse");
  property p_fe; $fell(serial_load_enable_n) |=> $stable(gain_code) [*3]; endproperty
  a_fe: assert property (p_fe) else $error("fall");
  c_ld: cover property (gain_update);
  c_mx: cover property (gain_update && gain_code > 7'h47);
  c_pd: cover property ($fell(power_down_n));
endmodule
bind serial_gain_word_loader gain_loader_monitor i_mon (.*);

// ==== verification/testbench.sv ====
// bench for the gain loader
// assumes host model and checker alongside
`timescale 1ns/1ps
module testbench;
  logic clk = 0, arst_n = 0, power_down_n = 1;
  logic serial_clk, serial_load_enable_n, serial_gain_data;
  logic [6:0] gain_code, applied_gain_step;
  logic forward_enable, reverse_enable, gain_update;
  int n_fail = 0, comparisons = 0, n_upd = 0, cyc = 0;
  always #5 clk = ~clk;
  gain_host_model i_gain_host_model (.*);
  serial_gain_word_loader i_serial_gain_word_loader (.*);
  always @(posedge clk) begin
    n_upd <= n_upd + (gain_update === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("counts n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // top bit is dropped, code above 71 clamps
  task automatic t_load(input logic [7:0] w);
    int u;
    u = n_upd;
    i_gain_host_model.send(w);
    check(gain_code, w[6:0]);
    check(applied_gain_step, w[6:0] > 7'h47 ? 7'h47 : w[6:0]);
    check(7'(n_upd - u), 7'h01);
    $display("test load %h done", w);
  endtask
  task automatic t_power();
    @(posedge clk);
    power_down_n <= 0;
    repeat (2) @(posedge clk);
    check(7'(reverse_enable), 7'h01);
    power_down_n <= 1;
    repeat (2) @(posedge clk);
    check(7'(forward_enable), 7'h01);
    $display("test power done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1;
    repeat (4) @(posedge clk);
    check(gain_code, 7'h00);
    t_load(8'h2A);
    t_load(8'hC7);
    t_load(8'h48);
    t_load(8'h80);
    t_load(8'hFF);
    t_power();
    conclude();
  end
endmodule
